// ---- src/dre_pkg.sv ----
/*
  Shared constants for the descriptor-memory loader: the controller's own
  register map, the device register map it drives, field positions and
  descriptor layout figures.
  Assumes the device map offsets below match the device being driven.
*/
package dre_pkg;
  // widths
  localparam int APB_AW = 8;
  localparam int DW     = 32;
  localparam int DEV_AW = 12;
  localparam int OFF_W  = 12;

  // controller register offsets (apb byte addresses)
  localparam logic [7:0] REG_CTRL       = 8'h00;
  localparam logic [7:0] REG_STATUS     = 8'h04;
  localparam logic [7:0] REG_CFG0       = 8'h08;
  localparam logic [7:0] REG_STAGE_ADDR = 8'h30;
  localparam logic [7:0] REG_STAGE_DATA = 8'h34;

  // configuration words, index from REG_CFG0
  localparam int CFG_NUM      = 10;
  localparam int CFG_STR_A    = 6;
  localparam int CFG_STR_B    = 7;
  localparam int CFG_HS_LEN   = 4;
  localparam int CFG_FS_LEN   = 5;
  localparam int CFG_FLAG     = 8;
  localparam int CFG_HW       = 9;
  localparam int SYSTEM_CONTROL_STATUS_REGS_NUM     = 4;
  localparam int CFG_LOAD_NUM = 9;

  // control and status bits
  localparam int CTRL_START    = 0;
  localparam int CTRL_PROT     = 1;
  localparam int STS_BUSY      = 0;
  localparam int STS_DONE      = 1;
  localparam int STS_LEN_ERR   = 2;
  localparam int STS_CONT_ERR  = 3;
  localparam int STS_EMU_ON    = 4;
  localparam int FLAG_WAKE_BIT = 0;

  // device register map
  localparam logic [11:0] DEV_STATION_UPPER = 12'h010;
  localparam logic [11:0] DEV_STATION_LOWER = 12'h014;
  localparam logic [11:0] DEV_LED_PIN_CFG   = 12'h018;
  localparam logic [11:0] DEV_PIN_WAKE      = 12'h01c;
  localparam logic [11:0] DEV_HS_LENGTHS    = 12'h020;
  localparam logic [11:0] DEV_FS_LENGTHS    = 12'h024;
  localparam logic [11:0] DEV_STR_LENGTHS_A = 12'h028;
  localparam logic [11:0] DEV_STR_LENGTHS_B = 12'h02c;
  localparam logic [11:0] DEV_FLAG_ATTRIBUTE_REG     = 12'h030;
  localparam logic [11:0] DEV_DP_SEL        = 12'h040;
  localparam logic [11:0] DEV_DP_ADDR       = 12'h044;
  localparam logic [11:0] DEV_DP_DATA       = 12'h048;
  localparam logic [11:0] DEV_DP_CMD        = 12'h04c;
  localparam logic [11:0] DEV_HARDWARE_CONFIG_REG        = 12'h050;

  // device field values
  localparam logic [31:0] DP_SEL_RAM  = 32'h0000_0001;
  localparam logic [31:0] MEMORY_TEST_MODE_ENABLE_MASK = 32'h8000_0000;
  localparam logic [31:0] DP_CMD_WR   = 32'h8000_0000;
  localparam logic [31:0] EEM_MASK    = 32'h0000_0100;
  localparam logic [31:0] RSTP_MASK   = 32'h0000_0200;

  // descriptor memory layout
  localparam int          DESC_COUNT    = 10;
  localparam int          DESC_HS_DEV   = 6;
  localparam int          DESC_HS_CFG   = 7;
  localparam int          STAGE_WORDS   = 128;
  localparam logic [11:0] RAM_BYTES     = 12'h200;
  localparam logic [11:0] LANG_SLOT_MIN = 12'h004;
  localparam logic [7:0]  DESC_LEN_18   = 8'h12;
  localparam int          CHK_PER_SPEED = 9;
  localparam int          CHK_NUM       = 18;

  // byte offsets and expected values inside descriptors
  localparam logic [11:0] OFS_BCD    = 12'h002;
  localparam logic [11:0] OFS_MAXPKT = 12'h007;
  localparam logic [11:0] OFS_NUMCFG = 12'h011;
  localparam logic [11:0] OFS_ISTR   = 12'h00e;
  localparam logic [11:0] OFS_ICFG   = 12'h006;
  localparam logic [11:0] OFS_BMATTR = 12'h007;
  localparam logic [7:0]  BCD_LO     = 8'h00;
  localparam logic [7:0]  BCD_HI     = 8'h02;
  localparam logic [7:0]  MAXPKT     = 8'h40;
  localparam logic [7:0]  NUMCFG     = 8'h01;
  localparam logic [7:0]  RWAKE_MASK = 8'h20;

  // sequencer states
  typedef enum logic [3:0] {
    ST_IDLE    = 4'h0,
    ST_SYSTEM_CONTROL_STATUS_REGS    = 4'h1,
    ST_ATTR    = 4'h2,
    ST_DPSEL   = 4'h3,
    ST_RAM     = 4'h4,
    ST_TESTOFF = 4'h5,
    ST_EEM     = 4'h6,
    ST_PROT    = 4'h7
  } dre_state_e;

  // device address of the n-th configuration word
  function automatic logic [11:0] dre_cfg_addr(input logic [3:0] n);
    logic [11:0] a;
    a = DEV_FLAG_ATTRIBUTE_REG;
    case (n)
      4'h0: a = DEV_STATION_UPPER;
      4'h1: a = DEV_STATION_LOWER;
      4'h2: a = DEV_LED_PIN_CFG;
      4'h3: a = DEV_PIN_WAKE;
      4'h4: a = DEV_HS_LENGTHS;
      4'h5: a = DEV_FS_LENGTHS;
      4'h6: a = DEV_STR_LENGTHS_A;
      4'h7: a = DEV_STR_LENGTHS_B;
      default: a = DEV_FLAG_ATTRIBUTE_REG;
    endcase
    return a;
  endfunction : dre_cfg_addr
endpackage : dre_pkg

// ---- src/dre_apb_slave.sv ----
/*
  APB slave front end for the loader's own registers.
  Assumes the parent decodes the address into hit and supplies read data
  combinationally for the address on the bus.
*/
`timescale 1ns/10ps
module dre_apb_slave (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       srst,
  // apb
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [dre_pkg::DW-1:0]     rdata,
  output logic      [dre_pkg::DW-1:0]     prdata,
  output logic                            pready,
  output logic                            pslverr,
  // register side
  input  wire logic                       hit,
  output logic                            wrEn
);
  import dre_pkg::*;

  // zero wait states, unmapped offsets answer with an error
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign wrEn    = psel & penable & pwrite & hit;

  // read data caught in the setup cycle so it is a flop in access
  always_ff @(posedge clk) begin
    if (srst) begin
      prdata <= '0;
    end else if (psel & ~penable & ~pwrite) begin
      prdata <= hit ? rdata : '0;
    end
  end
endmodule : dre_apb_slave

// ---- src/dre_dev_master.sv ----
/*
  Single-write master toward the device register interface.
  Assumes the device interface runs on clk and answers a held request with
  devAck, high for at least one cycle while devReq is high.
*/
`timescale 1ns/10ps
module dre_dev_master (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       srst,
  // request from the sequencer
  input  wire logic                       issue,
  input  wire logic [dre_pkg::DEV_AW-1:0] addr,
  input  wire logic [dre_pkg::DW-1:0]     data,
  output logic                            done,
  // device register interface
  output logic                            devReq,
  output logic      [dre_pkg::DEV_AW-1:0] devAddr,
  output logic      [dre_pkg::DW-1:0]     devWdata,
  input  wire logic                       devAck
);
  import dre_pkg::*;

  // completion is the edge where request and ack meet
  assign done = devReq & devAck;

  // request held with its address and data until acknowledged
  always_ff @(posedge clk) begin
    if (srst) begin
      devReq   <= 1'b0;
      devAddr  <= '0;
      devWdata <= '0;
    end else if (issue & ~devReq) begin
      devReq   <= 1'b1;
      devAddr  <= addr;
      devWdata <= data;
    end else if (devAck) begin
      devReq <= 1'b0;
    end
  end

  req_hold_a : assert property (@(posedge clk) disable iff (srst)
    devReq && !devAck |=> devReq && $stable(devAddr) && $stable(devWdata))
    else $error("device request dropped or changed before ack");
  req_drop_a : assert property (@(posedge clk) disable iff (srst)
    devReq && devAck |=> !devReq)
    else $error("device request not released after ack");
endmodule : dre_dev_master

// ---- src/dre_loader.sv ----
/*
  Descriptor-memory loader: drives a device with no configuration memory
  through its register interface. Software stages the system control
  words, the attribute words and up to 512 bytes of descriptors over APB,
  then writes start; the sequencer checks and writes them in order and
  finally enables emulation and, optionally, reset protection.
  Assumes a device register interface on clk with a request/ack handshake.

// Overview of operation
// (R1) order: control, attributes, memory, enable, protect
// (R2) attribute registers written before descriptor memory
// (R3) load station address, led select, wake fields
// (R4) lengths true; absent descriptors have length zero
// (R5) flag attributes hidden when device memory used
// (R6) configuration bmAttributes must agree with flag register
// (R7) descriptor memory holds 512 bytes via data port
// (R8) every descriptor starts dword aligned
// (R9) address zero reserved for language descriptor
// (R10) pack language, strings, hs then fs descriptors
// (R11) device descriptor length 0 or 18
// (R12) device replaces device descriptor type byte
// (R13) configuration group length 0 or 18
// (R14) device replaces configuration descriptor type byte
// (R15) absent strings referenced with index zero
// (R16) no strings means no language descriptor
// (R17) bcdUSB 0200h, max packet 40h, one config
// (R18) clear memory test mode after programming
// (R19) emulation bit selects memory and attribute sources
// (R20) reset protection keeps content except power-on
// (R21) emulation clear means configuration memory or defaults
*/
`timescale 1ns/10ps
module dre_loader (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       srst,
  // apb slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [dre_pkg::APB_AW-1:0] paddr,
  input  wire logic [dre_pkg::DW-1:0]     pwdata,
  output logic      [dre_pkg::DW-1:0]     prdata,
  output logic                            pready,
  output logic                            pslverr,
  // device register interface
  output logic                            devReq,
  output logic      [dre_pkg::DEV_AW-1:0] devAddr,
  output logic      [dre_pkg::DW-1:0]     devWdata,
  input  wire logic                       devAck
);
  import dre_pkg::*;

  dre_state_e  state;
  logic [3:0]  step;
  logic [7:0]  ramIdx;
  logic        pend;
  logic        done;
  logic        lenErr;
  logic        contErr;
  logic        emuOn;
  logic        protEn;
  logic        attrSeen;
  logic [6:0]  stageAddr;
  logic [31:0] cfg [CFG_NUM];
  logic [31:0] stage [STAGE_WORDS];

  wire         regWr;
  wire         issue;
  wire         devDone;
  wire         busy = (state != ST_IDLE);

  // length field legal only as absent or a full 18-byte descriptor
  function automatic logic lenLegal(input logic [7:0] l);
    return (l == 8'h00) || (l == DESC_LEN_18);
  endfunction : lenLegal

  // one content check: {enable, byte address, expected, mask}
  function automatic logic [28:0] chkSpec(input int k,
      input logic [11:0] dv, input logic [11:0] cf, input logic dvOn,
      input logic cfOn, input logic [4:0] strAbs, input logic wake);
    logic [28:0] r;
    r = '0;
    case (k)
      0: r = {dvOn, dv + OFS_BCD, BCD_LO, 8'hff};
      1: r = {dvOn, dv + OFS_BCD + 12'h001, BCD_HI, 8'hff};
      2: r = {dvOn, dv + OFS_MAXPKT, MAXPKT, 8'hff};
      3: r = {dvOn, dv + OFS_NUMCFG, NUMCFG, 8'hff};
      4, 5, 6: r = {dvOn & strAbs[k-4], dv + OFS_ISTR + 12'(k - 4),
                    8'h00, 8'hff};
      7: r = {cfOn, cf + OFS_BMATTR, wake ? RWAKE_MASK : 8'h00, RWAKE_MASK};
      8: r = {cfOn & strAbs[3], cf + OFS_ICFG, 8'h00, 8'hff};
      default: r = '0;
    endcase
    return r;
  endfunction : chkSpec

  // register decode
  wire        ctrlHit   = (paddr == REG_CTRL);
  wire        statusHit = (paddr == REG_STATUS);
  wire        stageAHit = (paddr == REG_STAGE_ADDR);
  wire        stageDHit = (paddr == REG_STAGE_DATA);
  wire [7:0]  cfgOfs    = paddr - REG_CFG0;
  wire        cfgHit    = (paddr >= REG_CFG0) && (paddr[1:0] == 2'b00) &&
                          (cfgOfs < 8'(CFG_NUM * 4));
  wire [3:0]  cfgIdx    = cfgOfs[5:2];
  wire        hit       = ctrlHit | statusHit | stageAHit | stageDHit |
                          cfgHit;
  wire [31:0] statusWord = {27'h0, emuOn, contErr, lenErr, done, busy};
  wire [31:0] rdata     = statusHit ? statusWord :
                          ctrlHit   ? {30'h0, protEn, 1'b0} :
                          cfgHit    ? cfg[cfgIdx] :
                          stageAHit ? {25'h0, stageAddr} : 32'h0;
  // staged content is frozen while a load runs
  wire        cfgWr     = regWr & cfgHit & ~busy;
  wire        stageWr   = regWr & stageDHit & ~busy;
  wire        startReq  = regWr & ctrlHit & pwdata[CTRL_START] & ~busy;

  dre_apb_slave u_apb (
    .clk     (clk),
    .srst    (srst),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .rdata   (rdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .hit     (hit),
    .wrEn    (regWr)
  );

  // software-visible configuration and staging memory
  always_ff @(posedge clk) begin
    if (srst) begin
      protEn    <= 1'b0;
      stageAddr <= '0;
      for (int i = 0; i < CFG_NUM; i++) cfg[i] <= '0;
    end else begin
      if (cfgWr) cfg[cfgIdx] <= pwdata;
      if (regWr & ctrlHit & ~busy) protEn <= pwdata[CTRL_PROT];
      if (regWr & stageAHit & ~busy) stageAddr <= pwdata[6:0];
      else if (stageWr) stageAddr <= stageAddr + 7'h01;
    end
  end

  // memory words are data, not control state: no reset needed
  always_ff @(posedge clk) begin
    if (stageWr) stage[stageAddr] <= pwdata;
  end

  // descriptor lengths in packing order
  logic [7:0]  lens [DESC_COUNT];
  logic [11:0] slot [DESC_COUNT];
  logic [11:0] off  [DESC_COUNT+1];
  logic [4:0]  strAbs;
  assign lens[0] = cfg[CFG_STR_A][7:0];
  assign lens[1] = cfg[CFG_STR_A][15:8];
  assign lens[2] = cfg[CFG_STR_A][23:16];
  assign lens[3] = cfg[CFG_STR_A][31:24];
  assign lens[4] = cfg[CFG_STR_B][7:0];
  assign lens[5] = cfg[CFG_STR_B][15:8];
  assign lens[6] = cfg[CFG_HS_LEN][7:0];
  assign lens[7] = cfg[CFG_HS_LEN][15:8];
  assign lens[8] = cfg[CFG_FS_LEN][7:0];
  assign lens[9] = cfg[CFG_FS_LEN][15:8];
  assign off[0]  = '0;

  // (R10) (R4) offsets from programmed lengths
  // (R9) language slot kept at zero even when empty
  for (genvar i = 0; i < DESC_COUNT; i++) begin : g_off
    assign slot[i] = (i == 0 && lens[i] == 8'h00) ? LANG_SLOT_MIN :
                     (({4'h0, lens[i]} + 12'h003) & 12'hffc);
    assign off[i+1] = off[i] + slot[i];
  end
  for (genvar j = 0; j < 5; j++) begin : g_abs
    assign strAbs[j] = (lens[j+1] == 8'h00);
  end

  // (R11) (R13) length legality; (R7) total fits the memory
  wire       lenBad  = !lenLegal(lens[6]) || !lenLegal(lens[7]) ||
                       !lenLegal(lens[8]) || !lenLegal(lens[9]) ||
                       (off[DESC_COUNT] > RAM_BYTES);
  wire [7:0] wordCnt = off[DESC_COUNT][9:2];
  wire [7:0] lastIdx = wordCnt - 8'h01;

  // content checks on each word as it is sent
  wire [31:0]        curWord = stage[ramIdx[6:0]];
  wire               ramChk  = issue && (state == ST_RAM) && (step == 4'h1);
  wire               flagWake = cfg[CFG_FLAG][FLAG_WAKE_BIT];
  logic [28:0]       spec [CHK_NUM];
  logic [CHK_NUM-1:0] bad;
  // (R17) fixed fields, (R15) absent string indexes, (R6) wake flag
  for (genvar s = 0; s < 2; s++) begin : g_spd
    for (genvar k = 0; k < CHK_PER_SPEED; k++) begin : g_chk
      localparam int N = s * CHK_PER_SPEED + k;
      assign spec[N] = chkSpec(k, off[DESC_HS_DEV + 2*s],
                               off[DESC_HS_CFG + 2*s],
                               lens[DESC_HS_DEV + 2*s] != 8'h00,
                               lens[DESC_HS_CFG + 2*s] != 8'h00,
                               strAbs, flagWake);
      assign bad[N] = ramChk && spec[N][28] &&
                      (spec[N][27:18] == {2'b00, ramIdx}) &&
                      (((curWord[{spec[N][17:16], 3'b000} +: 8] ^
                         spec[N][15:8]) & spec[N][7:0]) != 8'h00);
    end
  end

  // device write selection per state and step
  wire        cfgState = (state == ST_SYSTEM_CONTROL_STATUS_REGS) || (state == ST_ATTR);
  wire [31:0] hwBase   = cfg[CFG_HW] & ~(EEM_MASK | RSTP_MASK);
  wire [11:0] ramAddr  = (step == 4'h0) ? DEV_DP_ADDR :
                         (step == 4'h1) ? DEV_DP_DATA : DEV_DP_CMD;
  // (R8) byte address is always a whole word
  wire [31:0] ramData  = (step == 4'h0) ? {22'h0, ramIdx, 2'b00} :
                         (step == 4'h1) ? curWord : DP_CMD_WR;
  wire [11:0] wrAddr   = cfgState ? dre_cfg_addr(step) :
                         (state == ST_RAM) ? ramAddr :
                         (state == ST_DPSEL || state == ST_TESTOFF) ?
                         DEV_DP_SEL : DEV_HARDWARE_CONFIG_REG;
  wire [31:0] wrData   = cfgState ? cfg[step] :
                         (state == ST_RAM) ? ramData :
                         (state == ST_DPSEL) ? (DP_SEL_RAM | MEMORY_TEST_MODE_ENABLE_MASK) :
                         (state == ST_TESTOFF) ? DP_SEL_RAM :
                         (state == ST_EEM) ? (hwBase | EEM_MASK) :
                         (hwBase | EEM_MASK | RSTP_MASK);
  assign issue = busy & ~pend;

  dre_dev_master u_dev (
    .clk      (clk),
    .srst     (srst),
    .issue    (issue),
    .addr     (wrAddr),
    .data     (wrData),
    .done     (devDone),
    .devReq   (devReq),
    .devAddr  (devAddr),
    .devWdata (devWdata),
    .devAck   (devAck)
  );

  // sequencer: one device write per step, advanced on its completion
  always_ff @(posedge clk) begin
    if (srst) begin
      state   <= ST_IDLE;
      step    <= '0;
      ramIdx  <= '0;
      pend    <= 1'b0;
      done    <= 1'b0;
      lenErr  <= 1'b0;
      contErr <= 1'b0;
      emuOn   <= 1'b0;
    end else begin
      if (issue) pend <= 1'b1;
      else if (devDone) pend <= 1'b0;
      if (|bad) contErr <= 1'b1;
      if (startReq) begin
        // (R1) (R3) control fields go first; bad lengths refused
        done    <= lenBad;
        lenErr  <= lenBad;
        contErr <= 1'b0;
        emuOn   <= 1'b0;
        step    <= '0;
        ramIdx  <= '0;
        state   <= lenBad ? ST_IDLE : ST_SYSTEM_CONTROL_STATUS_REGS;
      end else if (devDone) begin
        unique case (state)
          ST_IDLE: state <= ST_IDLE;
          ST_SYSTEM_CONTROL_STATUS_REGS: begin
            step <= step + 4'h1;
            if (step == 4'(SYSTEM_CONTROL_STATUS_REGS_NUM - 1)) state <= ST_ATTR;
          end
          // (R2) attributes complete before the data port opens
          ST_ATTR: begin
            step <= (step == 4'(CFG_LOAD_NUM - 1)) ? 4'h0 : step + 4'h1;
            if (step == 4'(CFG_LOAD_NUM - 1)) state <= ST_DPSEL;
          end
          ST_DPSEL: state <= ST_RAM;
          ST_RAM: begin
            step <= (step == 4'h2) ? 4'h0 : step + 4'h1;
            if (step == 4'h2 && ramIdx == lastIdx) state <= ST_TESTOFF;
            else if (step == 4'h2) ramIdx <= ramIdx + 8'h01;
          end
          // (R18) test mode off; bad content never gets enabled
          ST_TESTOFF: begin
            state <= contErr ? ST_IDLE : ST_EEM;
            done  <= contErr;
          end
          ST_EEM: begin
            emuOn <= 1'b1;
            state <= protEn ? ST_PROT : ST_IDLE;
            done  <= ~protEn;
          end
          ST_PROT: begin
            state <= ST_IDLE;
            done  <= 1'b1;
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  // helper: flag attribute write seen since the last start
  always_ff @(posedge clk) begin
    if (srst || startReq) attrSeen <= 1'b0;
    else if (devDone && devAddr == DEV_FLAG_ATTRIBUTE_REG) attrSeen <= 1'b1;
  end

  attr_first_a : assert property (@(posedge clk) disable iff (srst) // (R2)
    devReq && devAddr == DEV_DP_DATA |-> attrSeen)
    else $error("descriptor data written before attribute registers");
  system_control_status_regs_first_a : assert property (@(posedge clk) disable iff (srst) // (R3)
    startReq && !lenBad |=> state == ST_SYSTEM_CONTROL_STATUS_REGS && step == 4'h0
      ##1 devReq && devAddr == DEV_STATION_UPPER)
    else $error("load did not start with the station address");
  dev_len_a : assert property (@(posedge clk) disable iff (srst) // (R11)
    devReq && devAddr == DEV_HS_LENGTHS |->
      lenLegal(devWdata[7:0]) && lenLegal(cfg[CFG_FS_LEN][7:0]))
    else $error("device descriptor length not 0 or 18 was sent");
  cfg_len_a : assert property (@(posedge clk) disable iff (srst) // (R13)
    state == ST_ATTR |-> lenLegal(lens[7]) && lenLegal(lens[9]))
    else $error("configuration length not 0 or 18 was sent");
  lang_zero_a : assert property (@(posedge clk) disable iff (srst) // (R9)
    $rose(state == ST_RAM) |-> ramIdx == 8'h00
      ##1 devReq && devAddr == DEV_DP_ADDR && devWdata == 32'h0)
    else $error("descriptor memory load did not begin at zero");
  ram_align_a : assert property (@(posedge clk) disable iff (srst) // (R8)
    devReq && devAddr == DEV_DP_ADDR |->
      devWdata[1:0] == 2'b00 && devWdata[31:2] < {22'h0, wordCnt})
    else $error("descriptor address misaligned or past the end");
  memory_test_mode_enable_off_a : assert property (@(posedge clk) disable iff (srst) // (R18)
    $rose(state == ST_EEM) |-> $past(state) == ST_TESTOFF &&
      $past(devWdata) == DP_SEL_RAM)
    else $error("emulation enabled before test mode was cleared");
  eem_gate_a : assert property (@(posedge clk) disable iff (srst) // (R1)
    devReq && devAddr == DEV_HARDWARE_CONFIG_REG |->
      !contErr && !lenErr && devWdata[8] && !attrSeen == 1'b0)
    else $error("emulation enable written out of order or after error");

  cov_prot_c : cover property (@(posedge clk)
    state == ST_PROT && devDone);
  cov_len_c : cover property (@(posedge clk)
    startReq && lenBad);
  cov_cont_c : cover property (@(posedge clk)
    state == ST_TESTOFF && devDone && contErr);
endmodule : dre_loader

// ---- verification/dre_dev_model.sv ----
/*
  device model: register writes with a slow ack and a descriptor memory.
  assumes the loader's device port on the same clk.
*/
`timescale 1ns/10ps
module dre_dev_model (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       srst,
  // register port
  input  wire logic                       devReq,
  input  wire logic [dre_pkg::DEV_AW-1:0] devAddr,
  input  wire logic [dre_pkg::DW-1:0]     devWdata,
  output logic                            devAck
);
  import dre_pkg::*;
  logic [1:0]  waitCnt;
  logic [31:0] ram [128];
  logic [7:0]  nWr;
  logic [7:0]  nHw;
  logic [31:0] hwCfg;
  logic [31:0] dpAddr;
  logic        attrDone;
  logic        orderErr;
  wire         take = devReq & devAck;
  // slow answer, three cycles into each request
  always_ff @(posedge clk) begin
    waitCnt <= (devReq & !devAck) ? waitCnt + 2'h1 : 2'h0;
    devAck  <= !srst & devReq & !devAck & (waitCnt == 2'h2);
  end
  // memory and source select, kept through srst
  always_ff @(posedge clk) begin
    if (srst) begin
      nWr      <= 8'h00;
      nHw      <= 8'h00;
      attrDone <= 1'b0;
      orderErr <= 1'b0;
    end else if (take) begin
      nWr <= nWr + 8'h01;
      if (devAddr == DEV_FLAG_ATTRIBUTE_REG) attrDone <= 1'b1;
      if (devAddr == DEV_DP_ADDR) dpAddr <= devWdata;
      // header bytes kept as stored
      if (devAddr == DEV_DP_DATA) ram[dpAddr[8:2]] <= devWdata;
      if (devAddr == DEV_DP_DATA && !attrDone) orderErr <= 1'b1;
      // hardware config word recorded and its writes counted
      if (devAddr == DEV_HARDWARE_CONFIG_REG) hwCfg <= devWdata;
      if (devAddr == DEV_HARDWARE_CONFIG_REG) nHw <= nHw + 8'h01;
    end
  end
endmodule : dre_dev_model

// ---- verification/dre_loader_test.sv ----
/*
  bench for dre_loader: apb tasks, device model, four tests.
  assumes the apb slave answers with pready and the model acks.
*/
`timescale 1ns/10ps
module dre_loader_test;
  import dre_pkg::*;
  logic              clk, srst, psel, penable, pwrite, pready, pslverr;
  logic [APB_AW-1:0] paddr;
  logic [DW-1:0]     pwdata, prdata, devWdata, rd;
  logic [DEV_AW-1:0] devAddr;
  logic              devReq, devAck, err;
  int                failures, check_count;
  dre_loader u_dre_loader (.clk(clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .devReq(devReq),
    .devAddr(devAddr), .devWdata(devWdata), .devAck(devAck));
  dre_dev_model u_dre_dev_model (.clk(clk), .srst(srst), .devReq(devReq),
    .devAddr(devAddr), .devWdata(devWdata), .devAck(devAck));
  // one apb transfer, held until pready
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    // no wait limit here: only the watchdog ends a hung access
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic chk(input string s, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  // start, then poll status until done
  task automatic run(input logic [31:0] c);
    apb(REG_CTRL, 1'b1, c);
    // a load that never finishes is caught by the watchdog
    do begin
      apb(REG_STATUS, 1'b0, 32'h0);
    end while (rd[STS_DONE] !== 1'b1);
  endtask : run
  task automatic test_regs;
    apb(REG_STATUS, 1'b0, 32'h0);
    chk("status reset", 32'h0, rd);
    apb(8'h3c, 1'b0, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    $display("test_regs done");
  endtask : test_regs
  task automatic test_badlen;
    apb(REG_CFG0 + 8'h10, 1'b1, 32'h0000_0011);
    run(32'h1);
    chk("len err", 32'h1, {31'h0, rd[STS_LEN_ERR]});
    chk("no writes", 32'h0, {24'h0, u_dre_dev_model.nWr});
    $display("test_badlen done");
  endtask : test_badlen
  task automatic test_load;
    logic [31:0] w [6];
    w = '{32'h0, 32'h0200_0112, 32'h4000_0000, 32'h0, 32'h0, 32'h0000_0100};
    apb(REG_CFG0 + 8'h10, 1'b1, 32'h0000_0012);
    apb(REG_STAGE_ADDR, 1'b1, 32'h0);
    foreach (w[i]) apb(REG_STAGE_DATA, 1'b1, w[i]);
    run(32'h3);
    chk("emu on", 32'h1, {31'h0, rd[STS_EMU_ON]});
    chk("write count", 32'h1f, {24'h0, u_dre_dev_model.nWr});
    chk("order", 32'h0, {31'h0, u_dre_dev_model.orderErr});
    chk("ram word1", w[1], u_dre_dev_model.ram[1]);
    chk("hardware_config_reg", 32'h300, u_dre_dev_model.hwCfg);
    $display("test_load done");
  endtask : test_load
  task automatic test_content;
    apb(REG_STAGE_ADDR, 1'b1, 32'h2);
    apb(REG_STAGE_DATA, 1'b1, 32'h0800_0000);
    run(32'h1);
    chk("cont err", 32'h1, {31'h0, rd[STS_CONT_ERR]});
    chk("emu off", 32'h0, {31'h0, rd[STS_EMU_ON]});
    chk("hw writes", 32'h2, {24'h0, u_dre_dev_model.nHw});
    $display("test_content done");
  endtask : test_content
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude
  // free-running clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // watchdog, far beyond three loads
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    conclude();
  end
  initial begin
    {srst, psel, penable, pwrite, paddr, pwdata} = {4'h8, 40'h0};
    failures = 0;
    check_count = 0;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    test_regs();
    test_badlen();
    test_load();
    test_content();
    conclude();
  end
endmodule : dre_loader_test
